// ===== rtl/idt_decode_tail.sv
`timescale 1ns/10ps
`include "idt_defines.svh"
// Function
// - Opcode 4d tests A in 2 cycles: N,Z from A, V and C cleared.
// - Opcode 5d tests B in 2 cycles: N,Z from B, V and C cleared.
// - Wait-for-irq spends 12 cycles from opcode fetch stacking registers.
// - Then it waits n whole cycles until an interrupt is recognized.
// - Two more cycles fetch the vector; whole sequence is 14 plus n.
// - Direct address is the operand byte with high byte zero.
// - Indexed address adds the unsigned operand byte to the index register.
// - Extended address takes high byte first, then low byte.
// - Sixteen-bit immediate takes high byte first, then low byte.
// - Eight-bit immediate uses the single following byte directly.
// - Relative target sign-extends offset and adds to following address.
// - Bit-manipulation affects only positions set in the mask.
// - Clear-only flags never become set, except in a cycle where a test op ends: then its N,Z from A or B override them.
module idt_decode_tail
  import idt_pkg::*;
#(
  parameter int WAIT_CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic irq_in,
  input wire logic addr_req_in,
  input wire idt_amode_t amode_in,
  input wire logic [7:0] opnd_hi_in,
  input wire logic [7:0] opnd_lo_in,
  input wire logic [15:0] next_pc_in,
  input wire logic [7:0] bit_data_in,
  input wire logic bit_set_in,
  input wire logic [7:0] ccr_clear_mask_in,
  input wire logic [7:0] ccr_new_in,
  input wire logic ccr_clear_only_in,
  output logic busy_out,
  output logic op_ready_out,
  output logic vec_fetch_out,
  output logic [15:0] ea_out,
  output logic [15:0] imm_out,
  output logic ea_valid_out,
  output logic [7:0] bit_result_out,
  output logic [7:0] wait_n_out,
  output idt_regs_t regs_out
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The wait counter lives in an 8-bit field, so wider settings cannot be served.
  if (WAIT_CNT_W < 1 || WAIT_CNT_W > 8) begin : g_bad_wait_w
    $error("WAIT_CNT_W must be 1 to 8");
  end
  // The shared step counter is four bits wide and must reach every end count.
  if (`IDT_CYC_WAIT_STACK > 15 || `IDT_CYC_XFER > 15 || `IDT_CYC_TEST > 15) begin : g_cyc_long
    $error("cycle counts must fit the 4-bit step counter");
  end
  // A count below two would still take two cycles, so it cannot be honoured.
  if (`IDT_CYC_TEST < 2 || `IDT_CYC_XFER < 2 || `IDT_CYC_WAIT_STACK < 2) begin : g_cyc_short
    $error("cycle counts below 2 cannot be served");
  end
  if (`IDT_CYC_VECTOR < 1) begin : g_cyc_vector
    $error("the vector fetch needs at least one cycle");
  end
  if (`IDT_CCR_N > 7 || `IDT_CCR_Z > 7 || `IDT_CCR_V > 7 ||
      `IDT_CCR_C > 7) begin : g_ccr_pos
    $error("flag positions must lie inside the condition register");
  end

  // The saturation point of the wait count follows the configured width.
  localparam logic [7:0] WAIT_MAX = 8'((9'h001 << WAIT_CNT_W) - 9'h001);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] nz_flags(input logic [7:0] ccr, input logic [7:0] v);
    logic [7:0] r;
    r = ccr;
    r[`IDT_CCR_N] = v[7];
    r[`IDT_CCR_Z] = (v == 8'h00);
    r[`IDT_CCR_V] = 1'b0;
    r[`IDT_CCR_C] = 1'b0;
    return r;
  endfunction

  function automatic logic [15:0] index_sel(input idt_regs_t r, input logic use_y);
    return use_y ? r.iy : r.ix;
  endfunction

  function automatic logic [15:0] sign_ext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // Effective address of the address-forming modes; immediate modes leave it alone.
  function automatic logic [15:0] operand_ea(input idt_amode_t m, input logic [7:0] hi,
      input logic [7:0] lo, input logic [15:0] index, input logic [15:0] pc,
      input logic [15:0] old);
    logic [15:0] r;
    r = old;
    case (m)
      IDT_AM_DIRECT: r = {8'h00, lo};
      IDT_AM_INDEXED: r = index + {8'h00, lo};
      IDT_AM_EXTENDED: r = {hi, lo};
      IDT_AM_RELATIVE: r = pc + sign_ext8(lo);
      default: r = old;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] operand_imm(input idt_amode_t m, input logic [7:0] hi,
      input logic [7:0] lo, input logic [15:0] old);
    logic [15:0] r;
    r = old;
    case (m)
      IDT_AM_IMM16: r = {hi, lo};
      IDT_AM_IMM8: r = {8'h00, lo};
      default: r = old;
    endcase
    return r;
  endfunction

  function automatic logic mode_known(input idt_amode_t m);
    logic r;
    r = 1'b0;
    case (m)
      IDT_AM_DIRECT, IDT_AM_INDEXED, IDT_AM_EXTENDED,
      IDT_AM_IMM8, IDT_AM_IMM16, IDT_AM_RELATIVE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Only mask-selected bits change; the rest keep the memory value.
  function automatic logic [7:0] mask_apply(input logic [7:0] data, input logic [7:0] mask,
      input logic set);
    return set ? (data | mask) : (data & ~mask);
  endfunction

  // A clear-only flag can only fall, so any attempted set is dropped.
  function automatic logic [7:0] clear_only(input logic [7:0] ccr, input logic [7:0] sel,
      input logic [7:0] val);
    return ccr & ~(sel & ~val);
  endfunction

  // The count sticks at its top value instead of wrapping to a misleading small n.
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic [7:0] top);
    logic [7:0] r;
    r = v;
    if (v < top) begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  function automatic logic is_test_op(input logic [7:0] op);
    return op == `IDT_OP_TEST_A || op == `IDT_OP_TEST_B;
  endfunction

  // Register moves of the three-cycle group; the prefix picks Y in place of X.
  function automatic idt_regs_t xfer_apply(input idt_regs_t r, input logic [7:0] op,
      input logic use_y);
    idt_regs_t n;
    n = r;
    case (op)
      `IDT_OP_SP_TO_X: begin
        if (use_y) begin
          n.iy = r.sp + 16'h0001;
        end else begin
          n.ix = r.sp + 16'h0001;
        end
      end
      `IDT_OP_X_TO_SP: n.sp = index_sel(r, use_y) - 16'h0001;
      `IDT_OP_SWAP_D: begin
        {n.a, n.b} = index_sel(r, use_y);
        if (use_y) begin
          n.iy = {r.a, r.b};
        end else begin
          n.ix = {r.a, r.b};
        end
      end
      default: begin
        n = r;
      end
    endcase
    return n;
  endfunction

  idt_state_all_t s, next_s;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    next_s = s;
    next_s.ea_valid = 1'b0;
    next_s.vec_fetch = 1'b0;
    next_s.op_ready = 1'b0;
    // Operand interpretation runs beside the opcode path; only the prefix flag from it picks the index register.
    if (addr_req_in) begin
      next_s.ea_valid = mode_known(amode_in);
      next_s.ea = operand_ea(amode_in, opnd_hi_in, opnd_lo_in,
          index_sel(s.regs, s.pre_y), next_pc_in, s.ea);
      next_s.imm = operand_imm(amode_in, opnd_hi_in, opnd_lo_in, s.imm);
      next_s.masked = mask_apply(bit_data_in, opnd_hi_in, bit_set_in);
    end
    if (ccr_clear_only_in) begin
      next_s.regs.ccr = clear_only(s.regs.ccr, ccr_clear_mask_in, ccr_new_in);
    end
    case (s.state)
      IDT_FETCH: begin
        next_s.busy = 1'b0;
        if (byte_valid_in) begin
          if (byte_in == `IDT_OP_PREFIX_Y && !s.pre_y) begin
            next_s.pre_y = 1'b1;
            next_s.busy = 1'b1;
          end else begin
            next_s.op = byte_in;
            next_s.busy = 1'b1;
            next_s.cnt = 4'h1;
            if (byte_in == `IDT_OP_WAIT) begin
              next_s.state = IDT_WAIT_STACK;
            end else begin
              next_s.state = IDT_EXEC;
            end
          end
        end
      end
      IDT_EXEC: begin
        next_s.cnt = s.cnt + 4'h1;
        // The prefix byte takes its own cycle outside this count, so a prefixed op runs one cycle longer.
        if (is_test_op(s.op)) begin
          if (s.cnt + 4'h1 >= `IDT_CYC_TEST) begin
            if (s.op == `IDT_OP_TEST_A) begin
              next_s.regs.ccr = nz_flags(s.regs.ccr, s.regs.a);
            end else begin
              next_s.regs.ccr = nz_flags(s.regs.ccr, s.regs.b);
            end
            next_s.state = IDT_FETCH;
            next_s.op_ready = 1'b1;
            next_s.pre_y = 1'b0;
          end
        end else if (s.cnt + 4'h1 >= `IDT_CYC_XFER) begin
          next_s.regs = xfer_apply(next_s.regs, s.op, s.pre_y);
          next_s.state = IDT_FETCH;
          next_s.op_ready = 1'b1;
          next_s.pre_y = 1'b0;
        end
      end
      IDT_WAIT_STACK: begin
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt + 4'h1 >= `IDT_CYC_WAIT_STACK) begin
          next_s.state = IDT_WAIT_IDLE;
          next_s.wait_n = 8'h00;
        end
      end
      IDT_WAIT_IDLE: begin
        // The cycle in which the interrupt is seen is one of the n wait cycles.
        next_s.wait_n = sat_inc(s.wait_n, WAIT_MAX);
        if (irq_in) begin
          next_s.state = IDT_WAIT_VECTOR;
          next_s.cnt = 4'h0;
        end
      end
      IDT_WAIT_VECTOR: begin
        next_s.vec_fetch = 1'b1;
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt + 4'h1 >= `IDT_CYC_VECTOR) begin
          next_s.state = IDT_FETCH;
          next_s.op_ready = 1'b1;
          next_s.pre_y = 1'b0;
        end
      end
      default: next_s.state = IDT_FETCH;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.state <= IDT_FETCH;
      s.regs.ccr <= `IDT_CCR_RESET;
      s.regs.sp <= `IDT_SP_RESET;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign busy_out = s.busy;
  assign op_ready_out = s.op_ready;
  assign vec_fetch_out = s.vec_fetch;
  assign ea_out = s.ea;
  assign imm_out = s.imm;
  assign ea_valid_out = s.ea_valid;
  assign bit_result_out = s.masked;
  assign wait_n_out = s.wait_n;
  assign regs_out = s.regs;

endmodule

// ===== rtl/idt_defines.svh
`ifndef IDT_DEFINES_SVH
`define IDT_DEFINES_SVH
`define IDT_OP_TEST_A 8'h4d
`define IDT_OP_TEST_B 8'h5d
`define IDT_OP_WAIT 8'h3e
`define IDT_OP_SP_TO_X 8'h30
`define IDT_OP_X_TO_SP 8'h35
`define IDT_OP_SWAP_D 8'h8f
`define IDT_OP_PREFIX_Y 8'h18
`define IDT_CYC_TEST 4'h2
`define IDT_CYC_XFER 4'h3
`define IDT_CYC_WAIT_STACK 4'hc
`define IDT_CYC_VECTOR 4'h2
`define IDT_CCR_C 0
`define IDT_CCR_V 1
`define IDT_CCR_Z 2
`define IDT_CCR_N 3
`define IDT_CCR_RESET 8'hd0
`define IDT_SP_RESET 16'h00ff
`endif

// ===== rtl/idt_pkg.sv
package idt_pkg;
  typedef enum logic [2:0] {
    IDT_FETCH,
    IDT_EXEC,
    IDT_WAIT_STACK,
    IDT_WAIT_IDLE,
    IDT_WAIT_VECTOR
  } idt_state_t;

  typedef enum logic [2:0] {
    IDT_AM_DIRECT,
    IDT_AM_INDEXED,
    IDT_AM_EXTENDED,
    IDT_AM_IMM8,
    IDT_AM_IMM16,
    IDT_AM_RELATIVE
  } idt_amode_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] sp;
    logic [7:0] ccr;
  } idt_regs_t;

  typedef struct packed {
    idt_state_t state;
    logic pre_y;
    logic [7:0] op;
    logic [3:0] cnt;
    logic [7:0] wait_n;
    idt_regs_t regs;
    logic [15:0] ea;
    logic [15:0] imm;
    logic [7:0] masked;
    logic ea_valid;
    logic busy;
    logic vec_fetch;
    logic op_ready;
  } idt_state_all_t;
endpackage

// ===== testbench/idt_decode_tail_properties.sv
`timescale 1ns/10ps
// ==========
// Port checker.
module idt_decode_tail_properties
  import idt_pkg::*;
#(
  parameter int WAIT_CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic addr_req_in,
  input wire idt_amode_t amode_in,
  input wire logic [7:0] opnd_hi_in,
  input wire logic [7:0] opnd_lo_in,
  input wire logic [15:0] next_pc_in,
  input wire logic [7:0] bit_data_in,
  input wire logic bit_set_in,
  input wire logic ccr_clear_only_in,
  input wire logic busy_out,
  input wire logic op_ready_out,
  input wire logic vec_fetch_out,
  input wire logic [15:0] ea_out,
  input wire logic [15:0] imm_out,
  input wire logic ea_valid_out,
  input wire logic [7:0] bit_result_out,
  input wire idt_regs_t regs_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic take;
  logic [7:0] ccr;
  logic [7:0] bres;
  logic [15:0] rel;
  assign take = ce_in && byte_valid_in && !busy_out;
  assign ccr = regs_out.ccr;
  assign bres = bit_set_in ? (bit_data_in | opnd_hi_in) : (bit_data_in & ~opnd_hi_in);
  assign rel = next_pc_in + {{8{opnd_lo_in[7]}}, opnd_lo_in};
  a_test_a_flags: assert property (
    take && byte_in == 8'h4d |-> ##2 op_ready_out && ccr[1:0] == 2'h0 &&
    ccr[3] == regs_out.a[7] && ccr[2] == (regs_out.a == 8'h00)) else $error("bad A test");
  a_test_b_flags: assert property (
    take && byte_in == 8'h5d |-> ##2 op_ready_out && ccr[1:0] == 2'h0 &&
    ccr[3] == regs_out.b[7] && ccr[2] == (regs_out.b == 8'h00)) else $error("bad B test");
  a_vector_two_cycles: assert property (
    $rose(vec_fetch_out) |-> busy_out ##1 vec_fetch_out ##1 !vec_fetch_out)
    else $error("vector fetch not two cycles");
  a_direct_page_zero: assert property (
    ce_in && addr_req_in && amode_in == IDT_AM_DIRECT |=> ea_valid_out &&
    ea_out == {8'h00, $past(opnd_lo_in)}) else $error("bad direct address");
  a_imm16_order: assert property (
    ce_in && addr_req_in && amode_in == IDT_AM_IMM16 |=>
    imm_out == {$past(opnd_hi_in), $past(opnd_lo_in)}) else $error("bad immediate order");
  a_rel_target: assert property (
    ce_in && addr_req_in && amode_in == IDT_AM_RELATIVE |=> ea_out == $past(rel))
    else $error("bad relative target");
  a_clear_only_flags: assert property (
    ccr_clear_only_in && !busy_out |=> (ccr & ~$past(ccr)) == 8'h00)
    else $error("clear-only set a flag");
  a_bit_mask_only: assert property (
    ce_in && addr_req_in |=> bit_result_out == $past(bres)) else $error("bad masked result");
  cover property (take && byte_in == 8'h3e);
  cover property ($rose(vec_fetch_out));
  cover property (ccr_clear_only_in);
endmodule
bind idt_decode_tail idt_decode_tail_properties #(.WAIT_CNT_W(WAIT_CNT_W)) u_chk (.*);

// ===== testbench/idt_decode_tail_tb_top.sv
`timescale 1ns/10ps
// ==========
// Bench: instructions go through the fetch model; operands are driven directly.
module idt_decode_tail_tb_top;
  import idt_pkg::*;
  logic clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, irq_in = 1'h0, addr_req_in = 1'h0;
  logic bit_set_in = 1'h0, ccr_clear_only_in = 1'h0, go = 1'h0, pre = 1'h0;
  logic byte_valid_in, busy_out, op_ready_out, vec_fetch_out, ea_valid_out;
  logic [7:0] byte_in, op = 8'h00, opnd_hi_in = 8'h00, opnd_lo_in = 8'h00;
  logic [7:0] bit_data_in = 8'hf0, ccr_clear_mask_in = 8'h00, ccr_new_in = 8'h00;
  logic [7:0] bit_result_out, wait_n_out;
  logic [15:0] next_pc_in = 16'h1234, ea_out, imm_out;
  idt_amode_t amode_in = IDT_AM_DIRECT;
  idt_regs_t regs_out;
  int miscompares = 0, n_tests = 0;
  idt_decode_tail #(.WAIT_CNT_W(8)) i_dut (.*);
  idt_fetch_model i_mem (.clk_in(clk_in), .go_in(go), .pre_in(pre), .op_in(op),
    .valid_out(byte_valid_in), .byte_out(byte_in));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Cycles are counted from the edge that takes the first byte, prefix included.
  task automatic run(input logic p, input logic [7:0] o, input int cyc, input int irq_at);
    int k;
    @(posedge clk_in);
    go <= 1'h1;
    pre <= p;
    op <= o;
    @(posedge clk_in);
    go <= 1'h0;
    @(posedge clk_in);
    for (k = 2; k < 60; k++) begin
      @(posedge clk_in);
      irq_in <= (k == irq_at);
      #1;
      if (op_ready_out === 1'h1)
        break;
    end
    chk(16'(k), 16'(cyc));
  endtask
  task automatic addr(input idt_amode_t m, input logic [7:0] h, input logic s);
    @(posedge clk_in);
    addr_req_in <= 1'h1;
    amode_in <= m;
    opnd_hi_in <= h;
    opnd_lo_in <= (m == IDT_AM_RELATIVE) ? 8'h80 : 8'h9a;
    bit_set_in <= s;
    @(posedge clk_in);
    addr_req_in <= 1'h0;
    #1;
  endtask
  task automatic t_xfer;
    chk(regs_out.sp, 16'h00ff);
    run(1'h0, 8'h30, 3, 0);
    chk(regs_out.ix, 16'h0100);
    run(1'h1, 8'h30, 4, 0);
    chk(regs_out.iy, 16'h0100);
    run(1'h0, 8'h35, 3, 0);
    chk(regs_out.sp, 16'h00ff);
  endtask
  task automatic t_addr;
    addr(IDT_AM_DIRECT, 8'h3c, 1'h1);
    chk(ea_out, 16'h009a);
    chk(16'(ea_valid_out), 16'h0001);
    chk(bit_result_out, 16'h00fc);
    addr(IDT_AM_INDEXED, 8'h3c, 1'h0);
    chk(ea_out, 16'h019a);
    chk(bit_result_out, 16'h00c0);
    addr(IDT_AM_EXTENDED, 8'h12, 1'h0);
    chk(ea_out, 16'h129a);
    addr(IDT_AM_IMM16, 8'h12, 1'h0);
    chk(imm_out, 16'h129a);
    addr(IDT_AM_IMM8, 8'h12, 1'h0);
    chk(imm_out, 16'h009a);
    addr(IDT_AM_RELATIVE, 8'h12, 1'h0);
    chk(ea_out, 16'h11b4);
  endtask
  // With the clock enable low nothing may move, not even a requested operand.
  task automatic t_freeze;
    @(posedge clk_in);
    ce_in <= 1'h0;
    addr(IDT_AM_EXTENDED, 8'h55, 1'h0);
    chk(ea_out, 16'h11b4);
    @(posedge clk_in);
    ce_in <= 1'h1;
  endtask
  task automatic t_test;
    run(1'h0, 8'h8f, 3, 0);
    chk(regs_out.a, 16'h0001);
    run(1'h0, 8'h4d, 2, 0);
    chk(regs_out.ccr, 16'h00d0);
    run(1'h0, 8'h5d, 2, 0);
    chk(regs_out.ccr, 16'h00d4);
    @(posedge clk_in);
    ccr_clear_only_in <= 1'h1;
    ccr_clear_mask_in <= 8'hff;
    ccr_new_in <= 8'h2f;
    @(posedge clk_in);
    ccr_clear_only_in <= 1'h0;
    #1;
    chk(regs_out.ccr, 16'h0004);
  endtask
  // Interrupt is raised at edge 18 and sampled at edge 19, so seven wait cycles follow the twelve stacking ones.
  task automatic t_wait;
    run(1'h0, 8'h3e, 21, 18);
    chk(16'(wait_n_out), 16'h0007);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    t_xfer;
    t_addr;
    t_freeze;
    t_test;
    t_wait;
    test_done;
  end
  initial begin
    #(4000 * 8);
    miscompares++;
    test_done;
  end
endmodule

// ===== testbench/idt_fetch_model.sv
`timescale 1ns/10ps
// ==========
// Fetch path model: offers one instruction, with an optional prefix byte first.
module idt_fetch_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic pre_in,
  input wire logic [7:0] op_in,
  output logic valid_out,
  output logic [7:0] byte_out
);
  logic hold = 1'h0;
  initial valid_out = 1'h0;
  initial byte_out = 8'h00;
  // Idle bus shows the inverse of the last byte so stale data never looks valid.
  always @(posedge clk_in) begin
    valid_out <= go_in | hold;
    hold <= go_in & pre_in;
    if (go_in & pre_in)
      byte_out <= 8'h18;
    else if (go_in | hold)
      byte_out <= op_in;
    else
      byte_out <= ~byte_out;
  end
endmodule
